// [pkg/obt_pkg.sv]
package obt_pkg;

    // widths of the time base, the stamp and the sample, and the channel count
    localparam int DC_TIME_W     = 64;
    localparam int STAMP_W       = 32;
    localparam int SAMPLE_W      = 16;
    localparam int CHAN_N        = 2;

    // clock figures
    localparam int CLK_PERIOD_NS = 25;

    // reset values
    localparam logic [STAMP_W-1:0]  STAMP_RST    = 32'h0000_0000;
    localparam logic [SAMPLE_W-1:0] SAMPLE_RST   = 16'h0000;
    localparam logic [15:0]         COUNT_RST    = 16'h0000;

    // one sample word of the stream towards the process data image
    typedef struct packed {
        logic                chan;
        logic [15:0]         step;
        logic [SAMPLE_W-1:0] value;
    } obt_sample_type;

    // pulse scheduler state
    typedef enum logic [1:0] {
        OBT_IDLE  = 2'b00,
        OBT_ARMED = 2'b01,
        OBT_RUN   = 2'b10
    } obt_state_type;

endpackage : obt_pkg

// [logic/obt_pulse_gen.sv]
`timescale 1ns/1ps
// periodic pulse generator on the local time: fires when the time reaches the
// programmed target, then moves the target on by the period
module obt_pulse_gen
    import obt_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 start_in,
    input  wire logic [DC_TIME_W-1:0] first_in,
    input  wire logic [DC_TIME_W-1:0] period_in,
    input  wire logic [DC_TIME_W-1:0] now_in,
    input  wire logic                 run_in,
    output logic                      pulse_out,
    output logic [DC_TIME_W-1:0]      target_out
);
    logic [DC_TIME_W-1:0] target_r;
    logic                 pulse_r;
    wire  logic           hit;

    // signed difference keeps the compare correct across wrap of the time
    assign hit = run_in && !start_in && !(($signed(now_in - target_r)) < 0);

    // target advances by whole periods, so no drift accumulates
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            target_r <= '0;
            pulse_r  <= 1'b0;
        end else begin
            pulse_r <= hit;
            if (start_in) begin
                target_r <= first_in;
            end else if (hit) begin
                target_r <= target_r + period_in;
            end
        end
    end

    assign pulse_out  = pulse_r;
    assign target_out = target_r;
endmodule : obt_pulse_gen

// [logic/obt_top.sv]
`timescale 1ns/1ps
// Contract
// - the next-block start time is given as a 32-bit unsigned word whenever its entry is enabled and the scheduler is running.
// - each cycle the reported time is that of the next slow pulse, which starts the next block.
// - the reported time steps by exactly the cycle time from one cycle to the next.
// - the reported time is the low 32 bits of the 64-bit local clock time.
// - each sample is 16 bits, one per oversampling step and active channel.
// - samples are evenly spaced by cycle time over factor, the first at the previous reported time.
// - a configurable shift time offsets both pulse trains.
// - each fast pulse triggers one conversion, so its interval is the sampling interval.
module obt_top
    import obt_pkg::*;
#(
    parameter int CHANS = CHAN_N
)
(
    input  wire logic                 CLK_IN,
    input  wire logic                 SYS_RST_IN,
    input  wire logic [DC_TIME_W-1:0] DC_TIME_IN,      // local clock time, same domain
    input  wire logic                 ENABLE_IN,       // start pulse trains
    input  wire logic                 STAMP_EN_IN,     // stamp entry enabled in process data
    input  wire logic [DC_TIME_W-1:0] CYCLE_TIME_IN,   // slow pulse interval, ns
    input  wire logic [DC_TIME_W-1:0] FAST_TIME_IN,    // fast pulse interval, ns
    input  wire logic [DC_TIME_W-1:0] SHIFT_TIME_IN,   // local shift, ns
    input  wire logic [DC_TIME_W-1:0] START_TIME_IN,   // first slow pulse, before shift
    input  wire logic [SAMPLE_W-1:0]  ADC_CH0_IN,      // converter result, async pin data
    input  wire logic [SAMPLE_W-1:0]  ADC_CH1_IN,
    input  wire logic                 ADC_DONE_IN,     // converter done, async pin
    output logic                      ADC_CONVERT_OUT,
    output logic                      SLOW_PULSE_OUT,
    output logic                      FAST_PULSE_OUT,
    output logic [STAMP_W-1:0]        NEXT_BLOCK_START_TIME_OUT,
    output logic                      STAMP_VALID_OUT,
    output obt_sample_type            SAMPLE_OUT,
    output logic                      SAMPLE_VALID_OUT,
    output logic [15:0]               STEPS_PER_BLOCK_OUT
);
    obt_state_type        state_r, state_nxt;
    logic [DC_TIME_W-1:0] first_r;
    logic                 start_r;
    logic                 slow_p, fast_p;
    logic [DC_TIME_W-1:0] slow_target;
    logic [STAMP_W-1:0]   stamp_r;
    logic                 stamp_v_r;
    logic                 conv_r;
    logic [15:0]          step_r, steps_r;
    logic                 done_s1_r, done_s2_r, done_s3_r;
    logic [SAMPLE_W-1:0]  ch0_s1_r, ch0_s2_r, ch1_s1_r, ch1_s2_r;
    logic [SAMPLE_W-1:0]  ch1_hold_r;
    logic                 ch1_pend_r;
    obt_sample_type       smp_r;
    logic                 smp_v_r;
    wire  logic           done_rise;
    wire  logic           slow_due;
    wire  logic [STAMP_W-1:0] stamp_nxt;

    // low 32 bits only; the natural truncation gives the silent wrap
    function automatic logic [STAMP_W-1:0] low_word(input logic [DC_TIME_W-1:0] t);
        return t[STAMP_W-1:0];
    endfunction : low_word

    // same signed test as the pulse generator, so the stamp moves on the very edge of the pulse
    function automatic logic due(input logic [DC_TIME_W-1:0] now, input logic [DC_TIME_W-1:0] target);
        return !($signed(now - target) < 0);
    endfunction : due

    // both trains start at the same shifted origin
    assign done_rise = done_s2_r && !done_s3_r;
    assign slow_due  = (state_r == OBT_RUN) && !start_r && due(DC_TIME_IN, slow_target);
    assign stamp_nxt = low_word(slow_target + CYCLE_TIME_IN);

    // scheduler: load origin once, then run until enable drops
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            OBT_IDLE:  if (ENABLE_IN) state_nxt = OBT_ARMED;
            OBT_ARMED: state_nxt = OBT_RUN;
            OBT_RUN:   if (!ENABLE_IN) state_nxt = OBT_IDLE;
            default:   state_nxt = OBT_IDLE;
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            state_r <= OBT_IDLE;
            start_r <= 1'b0;
            first_r <= '0;
        end else begin
            state_r <= state_nxt;
            start_r <= (state_r == OBT_IDLE) && ENABLE_IN;
            first_r <= START_TIME_IN + SHIFT_TIME_IN;
        end
    end

    // slow pulse: block boundary, interval is the cycle time
    obt_pulse_gen u_slow (
        .clk_in     (CLK_IN),
        .rst_in     (SYS_RST_IN),
        .start_in   (start_r),
        .first_in   (first_r),
        .period_in  (CYCLE_TIME_IN),
        .now_in     (DC_TIME_IN),
        .run_in     (state_r == OBT_RUN),
        .pulse_out  (slow_p),
        .target_out (slow_target)
    );

    // fast pulse: the ratio to the slow interval is the master's choice
    obt_pulse_gen u_fast (
        .clk_in     (CLK_IN),
        .rst_in     (SYS_RST_IN),
        .start_in   (start_r),
        .first_in   (first_r),
        .period_in  (FAST_TIME_IN),
        .now_in     (DC_TIME_IN),
        .run_in     (state_r == OBT_RUN),
        .pulse_out  (fast_p),
        .target_out ()
    );

    // stamp takes the origin at arming, then jumps to the following pulse time on the pulse edge
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            stamp_r   <= STAMP_RST;
            stamp_v_r <= 1'b0;
        end else begin
            if (start_r) begin
                stamp_r <= low_word(first_r);
            end else if (slow_due) begin
                stamp_r <= stamp_nxt;
            end
            stamp_v_r <= STAMP_EN_IN && (state_r == OBT_RUN);
        end
    end

    // one conversion per fast pulse; step counter restarts at block start
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            conv_r  <= 1'b0;
            step_r  <= COUNT_RST;
            steps_r <= COUNT_RST;
        end else begin
            conv_r <= fast_p;
            if (slow_p) begin
                steps_r <= step_r; // steps seen in the block just closed
                step_r  <= fast_p ? 16'h0001 : COUNT_RST;
            end else if (fast_p) begin
                step_r <= step_r + 16'h0001;
            end
        end
    end

    // converter pins come from outside, two flops before use
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
            done_s3_r <= 1'b0;
            ch0_s1_r  <= SAMPLE_RST;
            ch0_s2_r  <= SAMPLE_RST;
            ch1_s1_r  <= SAMPLE_RST;
            ch1_s2_r  <= SAMPLE_RST;
        end else begin
            done_s1_r <= ADC_DONE_IN;
            done_s2_r <= done_s1_r;
            done_s3_r <= done_s2_r;
            ch0_s1_r  <= ADC_CH0_IN;
            ch0_s2_r  <= ch0_s1_r;
            ch1_s1_r  <= ADC_CH1_IN;
            ch1_s2_r  <= ch1_s1_r;
        end
    end

    // channel 0 word first, channel 1 on the next cycle; 16-bit values
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            smp_r      <= '0;
            smp_v_r    <= 1'b0;
            ch1_hold_r <= SAMPLE_RST;
            ch1_pend_r <= 1'b0;
        end else begin
            smp_v_r <= 1'b0;
            if (done_rise) begin
                smp_r      <= '{chan: 1'b0, step: step_r, value: ch0_s2_r};
                smp_v_r    <= 1'b1;
                ch1_hold_r <= ch1_s2_r;
                ch1_pend_r <= (CHANS > 1);
            end else if (ch1_pend_r) begin
                smp_r      <= '{chan: 1'b1, step: smp_r.step, value: ch1_hold_r};
                smp_v_r    <= 1'b1;
                ch1_pend_r <= 1'b0;
            end
        end
    end

    assign ADC_CONVERT_OUT           = conv_r;
    assign SLOW_PULSE_OUT            = slow_p;
    assign FAST_PULSE_OUT            = fast_p;
    assign NEXT_BLOCK_START_TIME_OUT = stamp_r;
    assign STAMP_VALID_OUT           = stamp_v_r;
    assign SAMPLE_OUT                = smp_r;
    assign SAMPLE_VALID_OUT          = smp_v_r;
    assign STEPS_PER_BLOCK_OUT       = steps_r;
endmodule : obt_top

// [dv/obt_adc_model.sv]
`timescale 1ns/1ps
module obt_adc_model
    import obt_pkg::*;
(
    input  wire logic           clk_in,
    input  wire logic           convert_in,
    output logic [SAMPLE_W-1:0] ch0_out,
    output logic [SAMPLE_W-1:0] ch1_out,
    output logic                done_out
);
    initial done_out = 1'b0;
    initial ch0_out = 16'h0000;
    initial ch1_out = 16'h0000;
    // one conversion per request; data lines toggle while converting, so stale data is never a match
    // done stands three cycles so the two-flop synchroniser cannot miss the edge
    always @(posedge clk_in) if (convert_in === 1'b1) begin
        #1 ch0_out = ~ch0_out;
        ch1_out = ~ch1_out;
        @(posedge clk_in) #1 ch0_out = 16'($urandom);
        ch1_out = 16'($urandom);
        @(posedge clk_in) #1 done_out = 1'b1;
        repeat (3) @(posedge clk_in);
        #1 done_out = 1'b0;
    end
endmodule : obt_adc_model

// [dv/obt_checker.sv]
`timescale 1ns/1ps
module obt_checker
    import obt_pkg::*;
(
    input wire logic                 CLK_IN,
    input wire logic                 SYS_RST_IN,
    input wire logic                 STAMP_EN_IN,
    input wire logic                 ADC_DONE_IN,
    input wire logic [DC_TIME_W-1:0] CYCLE_TIME_IN,
    input wire logic                 ADC_CONVERT_OUT,
    input wire logic                 SLOW_PULSE_OUT,
    input wire logic                 FAST_PULSE_OUT,
    input wire logic [STAMP_W-1:0]   NEXT_BLOCK_START_TIME_OUT,
    input wire logic                 STAMP_VALID_OUT,
    input wire obt_sample_type       SAMPLE_OUT,
    input wire logic                 SAMPLE_VALID_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // block start and first sample coincide; each fast pulse converts once
    slow_with_fast_a: assert property (SLOW_PULSE_OUT |-> FAST_PULSE_OUT) else $error("slow without fast");
    convert_follow_a: assert property (FAST_PULSE_OUT |=> ADC_CONVERT_OUT) else $error("no convert");
    convert_cause_a: assert property (ADC_CONVERT_OUT |-> $past(FAST_PULSE_OUT)) else $error("stray convert");
    fast_single_a: assert property (FAST_PULSE_OUT |=> !FAST_PULSE_OUT) else $error("fast pulse too long");
    // stamp moves by one cycle time, modulo the 32-bit range, at a slow pulse, and holds in the cycle after it
    stamp_step_a: assert property (SLOW_PULSE_OUT |-> NEXT_BLOCK_START_TIME_OUT ==
        $past(NEXT_BLOCK_START_TIME_OUT) + CYCLE_TIME_IN[31:0]) else $error("stamp step wrong");
    stamp_hold_a: assert property (SLOW_PULSE_OUT |=> $stable(NEXT_BLOCK_START_TIME_OUT)) else $error("stamp moved");
    valid_off_a: assert property ($past(!STAMP_EN_IN) |-> !STAMP_VALID_OUT) else $error("stamp valid when off");
    // channel 0 word comes 3 cycles after done, channel 1 right behind with the same step
    sample_cause_a: assert property (SAMPLE_VALID_OUT && !SAMPLE_OUT.chan |-> $past(ADC_DONE_IN, 3))
        else $error("sample without done");
    pair_order_a: assert property (SAMPLE_VALID_OUT && !SAMPLE_OUT.chan |=> SAMPLE_VALID_OUT && SAMPLE_OUT.chan
        && SAMPLE_OUT.step == $past(SAMPLE_OUT.step)) else $error("channel pair broken");
    cover property (SLOW_PULSE_OUT);
    cover property (SAMPLE_VALID_OUT && SAMPLE_OUT.chan);
    cover property (STAMP_VALID_OUT);
endmodule : obt_checker
bind obt_top obt_checker obt_checker_inst (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .STAMP_EN_IN(STAMP_EN_IN),
    .ADC_DONE_IN(ADC_DONE_IN), .CYCLE_TIME_IN(CYCLE_TIME_IN), .ADC_CONVERT_OUT(ADC_CONVERT_OUT),
    .SLOW_PULSE_OUT(SLOW_PULSE_OUT), .FAST_PULSE_OUT(FAST_PULSE_OUT), .STAMP_VALID_OUT(STAMP_VALID_OUT),
    .NEXT_BLOCK_START_TIME_OUT(NEXT_BLOCK_START_TIME_OUT), .SAMPLE_OUT(SAMPLE_OUT), .SAMPLE_VALID_OUT(SAMPLE_VALID_OUT));

// [dv/oversample_block_timestamp_test.sv]
`timescale 1ns/1ps
module oversample_block_timestamp_test;
    import obt_pkg::*;
    // time base starts just below 2**32 so the stamp wraps within the run
    localparam logic [63:0] T0 = 64'h0000_0000_FFFF_FC00;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic           en  = 1'b0;
    logic           sen = 1'b0;
    logic           ch  = 1'b0;
    logic [63:0]    now = T0;
    logic [63:0]    cyc = 64'h3E8;
    logic [63:0]    fst = 64'hFA;
    logic [63:0]    sh  = 64'h0;
    logic [31:0]    exp_nb, es, nb;
    logic [15:0]    d0, d1, spb;
    logic           dn, cv, sp, fp, sv, smv;
    obt_sample_type so;
    int             err_total = 0, n_checks = 0, blk = 0, stp = 0;
    obt_top obt_top_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .DC_TIME_IN(now), .ENABLE_IN(en), .STAMP_EN_IN(sen),
        .CYCLE_TIME_IN(cyc), .FAST_TIME_IN(fst), .SHIFT_TIME_IN(sh), .START_TIME_IN(T0 + 64'h1F4),
        .ADC_CH0_IN(d0), .ADC_CH1_IN(d1), .ADC_DONE_IN(dn), .ADC_CONVERT_OUT(cv), .SLOW_PULSE_OUT(sp),
        .FAST_PULSE_OUT(fp), .NEXT_BLOCK_START_TIME_OUT(nb), .STAMP_VALID_OUT(sv), .SAMPLE_OUT(so),
        .SAMPLE_VALID_OUT(smv), .STEPS_PER_BLOCK_OUT(spb));
    obt_adc_model obt_adc_model_inst (.clk_in(clk), .convert_in(cv), .ch0_out(d0), .ch1_out(d1), .done_out(dn));
    initial forever #12.5 clk = ~clk;
    // local clock time advances 25 ns per cycle, like the real time base
    always @(posedge clk) #1 now = now + 64'h19;
    task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask : chk
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    // reference model at the falling edge, where outputs have settled
    always @(negedge clk) if (!rst && en) begin
        if (sp === 1'b1) begin
            exp_nb = exp_nb + cyc[31:0];
            blk = blk + 1;
            chk(nb, exp_nb, "stamp");
            chk(now[31:0] - (exp_nb - cyc[31:0]) < 32'h64, 1, "pulse late");
        end
        if (fp === 1'b1) begin
            stp = (sp === 1'b1) ? 1 : stp + 1;
            es = stp;
            if (blk > 1 && stp == 2) chk(spb, cyc / fst, "steps");
        end
        if (smv === 1'b1) chk({so.chan, so.step, so.value}, {ch, es[15:0], ch ? d1 : d0}, "sample");
        if (smv === 1'b1) ch = ~ch;
    end
    initial begin
        void'($urandom(32'h3E00));
        sh = 64'($urandom_range(300, 0));
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        exp_nb = T0[31:0] + 32'h1F4 + sh[31:0];
        @(posedge clk) #1 en = 1'b1;
        sen = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(nb, exp_nb, "arm");
        chk(sv, 1, "valid");
        $display("test arm done");
        repeat (260) @(posedge clk);
        chk(blk > 5, 1, "blocks");
        $display("test blocks done");
        #1 sen = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(sv, 0, "valid off");
        $display("test enable done");
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({nb, sv, smv}, 0, "reset");
        $display("test reset done");
        summarize;
    end
    // the run needs about 280 cycles; a hang is cut off well past that
    initial begin
        #20000;
        err_total++;
        summarize;
    end
endmodule : oversample_block_timestamp_test
